// ==== logic/mcu_core_regs.svh ====
// constants for the 8-bit core datapath: widths, addresses, flag bits, opcodes
`ifndef MCU_CORE_REGS_SVH
`define MCU_CORE_REGS_SVH

// ==================================================================
// widths
`define INSN_W 12
`define DATA_W 8
`define PC_W 10
`define FADDR_W 5

// ==================================================================
// mapped register addresses
`define ADDR_INDF 5'h00
`define ADDR_PCL 5'h02
`define ADDR_STATUS 5'h03
`define ADDR_FSR 5'h04

// ==================================================================
// status bit positions and reset values
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define STATUS_RESET 8'h18
`define PC_RESET 10'h000
`define W_RESET 8'h00
`define FSR_RESET 8'h00

// ==================================================================
// opcode fields
`define NOP_WORD 12'h000
`define OP_BYTE 4'h0
`define OP_BYTE2 4'h1
`define OP_BYTE3 4'h2
`define OP_BYTE4 4'h3
`define OP_GOTO 3'h5
`define OP_CALL 4'h9
`define OP_RETLW 4'h8
`define OP_MOVLW 4'hc
`define OP_IORLW 4'hd
`define OP_ANDLW 4'he
`define OP_XORLW 4'hf

`endif

// ==== logic/mcu_core_pkg.sv ====
// types shared by the core datapath modules
package mcu_core_pkg;

    // ==================================================================
    // alu operations
    typedef enum logic [3:0] {
        ALU_PASS_A = 4'h0,
        ALU_PASS_B = 4'h1,
        ALU_ADD = 4'h2,
        ALU_SUB = 4'h3,
        ALU_AND = 4'h4,
        ALU_IOR = 4'h5,
        ALU_XOR = 4'h6,
        ALU_COM = 4'h7,
        ALU_INC = 4'h8,
        ALU_DEC = 4'h9,
        ALU_RLF = 4'ha,
        ALU_RRF = 4'hb,
        ALU_SWAP = 4'hc,
        ALU_CLR = 4'hd
    } alu_op_t;

    // pipeline slot state, one-hot
    typedef enum logic [1:0] {
        SLOT_RUN = 2'b01,
        SLOT_FLUSH = 2'b10
    } slot_t;

endpackage : mcu_core_pkg

// ==== logic/mcu_alu.sv ====
// 8-bit alu with result, carry and nibble carry outputs
`timescale 1ns/1ns
`include "mcu_core_regs.svh"

module mcu_alu (
    input wire mcu_core_pkg::alu_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic carry_out,
    output logic nibble_out
);
    logic [8:0] sum;
    logic [4:0] low;

    // ==================================================================
    // operation select; subtraction is a + ~b + 1, so carry is inverted borrow
    always_comb begin
        sum = 9'h000;
        low = 5'h00;
        result = a;
        carry_out = carry_in;
        nibble_out = 1'b0;
        case (op)
            mcu_core_pkg::ALU_PASS_A: result = a;
            mcu_core_pkg::ALU_PASS_B: result = b;
            mcu_core_pkg::ALU_ADD: begin
                sum = {1'b0, a} + {1'b0, b};
                low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
                result = sum[7:0];
                carry_out = sum[8];
                nibble_out = low[4];
            end
            mcu_core_pkg::ALU_SUB: begin
                sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
                low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
                result = sum[7:0];
                carry_out = sum[8];
                nibble_out = low[4];
            end
            mcu_core_pkg::ALU_AND: result = a & b;
            mcu_core_pkg::ALU_IOR: result = a | b;
            mcu_core_pkg::ALU_XOR: result = a ^ b;
            mcu_core_pkg::ALU_COM: result = ~a;
            mcu_core_pkg::ALU_INC: result = a + 8'h01;
            mcu_core_pkg::ALU_DEC: result = a - 8'h01;
            mcu_core_pkg::ALU_RLF: begin
                result = {a[6:0], carry_in};
                carry_out = a[7];
            end
            mcu_core_pkg::ALU_RRF: begin
                result = {carry_in, a[7:1]};
                carry_out = a[0];
            end
            mcu_core_pkg::ALU_SWAP: result = {a[3:0], a[7:4]};
            mcu_core_pkg::ALU_CLR: result = 8'h00;
            default: result = a;
        endcase
    end
endmodule : mcu_alu

// ==== logic/mcu_decode.sv ====
// instruction decoder: one 12-bit word to alu and write-back controls
`timescale 1ns/1ns
`include "mcu_core_regs.svh"

module mcu_decode (
    input wire logic [11:0] insn,
    output mcu_core_pkg::alu_op_t op,
    output logic use_lit,
    output logic to_file,
    output logic wr_en,
    output logic upd_z,
    output logic upd_c,
    output logic upd_dc,
    output logic skip_zero,
    output logic is_goto,
    output logic is_call,
    output logic is_ret,
    output logic is_bit,
    output logic bit_val,
    output logic bit_test
);
    logic [5:0] sub;

    // ==================================================================
    // decode of byte, bit and literal groups
    always_comb begin
        sub = insn[11:6];
        op = mcu_core_pkg::ALU_PASS_A;
        use_lit = 1'b0;
        to_file = insn[5];
        wr_en = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        skip_zero = 1'b0;
        is_goto = 1'b0;
        is_call = 1'b0;
        is_ret = 1'b0;
        is_bit = 1'b0;
        bit_val = insn[8];
        bit_test = 1'b0;
        if (insn[11:10] == 2'b00) begin
            wr_en = 1'b1;
            case (sub[3:0])
                4'h0: begin
                    op = mcu_core_pkg::ALU_PASS_B;
                    wr_en = insn[5];
                end
                4'h1: begin
                    op = mcu_core_pkg::ALU_CLR;
                    upd_z = 1'b1;
                end
                4'h2: begin
                    op = mcu_core_pkg::ALU_SUB;
                    {upd_z, upd_c, upd_dc} = 3'b111;
                end
                4'h3: op = mcu_core_pkg::ALU_DEC;
                4'h4: begin
                    op = mcu_core_pkg::ALU_IOR;
                    upd_z = 1'b1;
                end
                4'h5: begin
                    op = mcu_core_pkg::ALU_AND;
                    upd_z = 1'b1;
                end
                4'h6: begin
                    op = mcu_core_pkg::ALU_XOR;
                    upd_z = 1'b1;
                end
                4'h7: begin
                    op = mcu_core_pkg::ALU_ADD;
                    {upd_z, upd_c, upd_dc} = 3'b111;
                end
                4'h8: begin
                    op = mcu_core_pkg::ALU_PASS_A;
                    upd_z = 1'b1;
                end
                4'h9: begin
                    op = mcu_core_pkg::ALU_COM;
                    upd_z = 1'b1;
                end
                4'ha: begin
                    op = mcu_core_pkg::ALU_INC;
                    upd_z = 1'b1;
                end
                4'hb: begin
                    op = mcu_core_pkg::ALU_DEC;
                    skip_zero = 1'b1;
                end
                4'hc: begin
                    op = mcu_core_pkg::ALU_RRF;
                    upd_c = 1'b1;
                end
                4'hd: begin
                    op = mcu_core_pkg::ALU_RLF;
                    upd_c = 1'b1;
                end
                4'he: op = mcu_core_pkg::ALU_SWAP;
                4'hf: begin
                    op = mcu_core_pkg::ALU_INC;
                    skip_zero = 1'b1;
                end
                default: wr_en = 1'b0;
            endcase
            // opcode 0x000 and 0x040 forms without file bit are no-ops or clrw
            if (sub[3:0] == 4'h0 && insn[5] == 1'b0) begin
                wr_en = 1'b0;
            end
            if (sub[3:0] == 4'h3) begin
                op = mcu_core_pkg::ALU_DEC;
                upd_z = 1'b1;
            end
        end else if (insn[11:10] == 2'b01) begin
            is_bit = 1'b1;
            to_file = 1'b1;
            bit_test = insn[9];
            wr_en = ~insn[9];
        end else if (insn[11:9] == `OP_GOTO) begin
            is_goto = 1'b1;
        end else begin
            use_lit = 1'b1;
            to_file = 1'b0;
            case (insn[11:8])
                `OP_RETLW: begin
                    is_ret = 1'b1;
                    op = mcu_core_pkg::ALU_PASS_B;
                    wr_en = 1'b1;
                end
                `OP_CALL: is_call = 1'b1;
                `OP_MOVLW: begin
                    op = mcu_core_pkg::ALU_PASS_B;
                    wr_en = 1'b1;
                end
                `OP_IORLW: begin
                    op = mcu_core_pkg::ALU_IOR;
                    wr_en = 1'b1;
                    upd_z = 1'b1;
                end
                `OP_ANDLW: begin
                    op = mcu_core_pkg::ALU_AND;
                    wr_en = 1'b1;
                    upd_z = 1'b1;
                end
                `OP_XORLW: begin
                    op = mcu_core_pkg::ALU_XOR;
                    wr_en = 1'b1;
                    upd_z = 1'b1;
                end
                default: wr_en = 1'b0;
            endcase
        end
    end
endmodule : mcu_decode

// ==== logic/mcu_core.sv ====
// two-stage core datapath: fetch, decode, alu, flags, mapped registers
`timescale 1ns/1ns
`include "mcu_core_regs.svh"

module mcu_core (
    input wire logic clk,
    input wire logic rst,
    output logic [9:0] prog_addr,
    input wire logic [11:0] prog_data,
    output logic [4:0] data_addr,
    input wire logic [7:0] data_rdata,
    output logic [7:0] data_wdata,
    output logic data_we,
    output logic [7:0] w_value,
    output logic [7:0] status_value,
    output logic flushing
);
    // ==================================================================
    // state
    typedef struct packed {
        logic [9:0] pc;
        logic [11:0] ir;
        mcu_core_pkg::slot_t slot;
        logic [7:0] w;
        logic [7:0] status;
        logic [7:0] fsr;
        logic [9:0] stack0;
        logic [9:0] stack1;
    } core_state_t;

    core_state_t cur;
    core_state_t next_cur;

    mcu_core_pkg::alu_op_t op;
    logic use_lit;
    logic to_file;
    logic wr_en;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic skip_zero;
    logic is_goto;
    logic is_call;
    logic is_ret;
    logic is_bit;
    logic bit_val;
    logic bit_test;
    logic [4:0] eff_addr;
    logic [7:0] file_val;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_dc;
    logic [7:0] bit_mask;
    logic [7:0] wb_val;
    logic executing;
    logic branch;

    // ==================================================================
    // decoder and alu
    mcu_decode u_decode (
        .insn(cur.ir),
        .op(op),
        .use_lit(use_lit),
        .to_file(to_file),
        .wr_en(wr_en),
        .upd_z(upd_z),
        .upd_c(upd_c),
        .upd_dc(upd_dc),
        .skip_zero(skip_zero),
        .is_goto(is_goto),
        .is_call(is_call),
        .is_ret(is_ret),
        .is_bit(is_bit),
        .bit_val(bit_val),
        .bit_test(bit_test)
    );

    mcu_alu u_alu (
        .op(op),
        .a(alu_a),
        .b(alu_b),
        .carry_in(cur.status[`ST_CARRY]),
        .result(alu_res),
        .carry_out(alu_c),
        .nibble_out(alu_dc)
    );

    // ==================================================================
    // operand fetch: indirect via pointer, mapped registers read locally
    always_comb begin
        executing = (cur.slot == mcu_core_pkg::SLOT_RUN);
        eff_addr = (cur.ir[4:0] == `ADDR_INDF) ? cur.fsr[4:0] : cur.ir[4:0];
        case (eff_addr)
            `ADDR_PCL: file_val = cur.pc[7:0];
            `ADDR_STATUS: file_val = cur.status;
            `ADDR_FSR: file_val = cur.fsr;
            `ADDR_INDF: file_val = 8'h00;
            default: file_val = data_rdata;
        endcase
        // byte ops take file as a; literal forms pair w with the literal
        alu_a = use_lit ? cur.w : file_val;
        alu_b = use_lit ? cur.ir[7:0] : cur.w;
        if (op == mcu_core_pkg::ALU_SUB) begin
            alu_a = file_val;
            alu_b = cur.w;
        end
        if (op == mcu_core_pkg::ALU_PASS_B && !use_lit) begin
            alu_b = cur.w;
        end
        bit_mask = 8'h01 << cur.ir[7:5];
        wb_val = is_bit ? (bit_val ? (file_val | bit_mask) : (file_val & ~bit_mask)) : alu_res;
    end

    // ==================================================================
    // next state: execute current word while fetching the next
    always_comb begin
        next_cur = cur;
        branch = 1'b0;
        next_cur.slot = mcu_core_pkg::SLOT_RUN;
        next_cur.ir = prog_data;
        next_cur.pc = cur.pc + 10'h001;
        data_we = 1'b0;
        data_wdata = wb_val;
        if (executing) begin
            if (is_goto) begin
                next_cur.pc = {1'b0, cur.ir[8:0]}; // nine-bit jump field
                branch = 1'b1;
            end else if (is_call) begin
                next_cur.stack1 = cur.stack0;
                next_cur.stack0 = cur.pc;
                next_cur.pc = {2'b00, cur.ir[7:0]};
                branch = 1'b1;
            end else if (is_ret) begin
                next_cur.pc = cur.stack0;
                next_cur.stack0 = cur.stack1;
                next_cur.w = cur.ir[7:0];
                branch = 1'b1;
            end else if (is_bit && bit_test) begin
                if (file_val[cur.ir[7:5]] == cur.ir[8]) begin
                    branch = 1'b1; // skip by flushing the fetched word
                end
            end else begin
                if (skip_zero && alu_res == 8'h00) begin
                    branch = 1'b1;
                end
                if (upd_z) begin
                    next_cur.status[`ST_ZERO] = (alu_res == 8'h00);
                end
                if (upd_c) begin
                    next_cur.status[`ST_CARRY] = alu_c;
                end
                if (upd_dc) begin
                    next_cur.status[`ST_NIBBLE] = alu_dc;
                end
                if (wr_en && !to_file && !is_bit) begin
                    next_cur.w = wb_val;
                end
            end
            if (wr_en && (to_file || is_bit)) begin
                case (eff_addr)
                    `ADDR_PCL: begin
                        next_cur.pc = {cur.pc[9:8], wb_val};
                        branch = 1'b1;
                    end
                    `ADDR_STATUS: next_cur.status = wb_val;
                    `ADDR_FSR: next_cur.fsr = wb_val;
                    `ADDR_INDF: data_we = 1'b0;
                    default: data_we = 1'b1;
                endcase
            end
        end
        if (branch) begin
            next_cur.slot = mcu_core_pkg::SLOT_FLUSH;
            next_cur.ir = `NOP_WORD;
        end
    end

    // ==================================================================
    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cur.pc <= `PC_RESET;
            cur.ir <= `NOP_WORD;
            cur.slot <= mcu_core_pkg::SLOT_FLUSH;
            cur.w <= `W_RESET;
            cur.status <= `STATUS_RESET;
            cur.fsr <= `FSR_RESET;
            cur.stack0 <= `PC_RESET;
            cur.stack1 <= `PC_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // fetch address runs ahead of execution; data port works in parallel
    assign prog_addr = cur.pc;
    assign data_addr = eff_addr;
    assign w_value = cur.w;
    assign status_value = cur.status;
    assign flushing = (cur.slot == mcu_core_pkg::SLOT_FLUSH);

    // ==================================================================
    // checks
    a_pc_advance: assert property (@(posedge clk) disable iff (rst)
        (executing && !branch) |=> (prog_addr == $past(prog_addr) + 10'h001))
        else $error("pc did not advance by one");
    a_branch_flush: assert property (@(posedge clk) disable iff (rst)
        (executing && branch) |=> flushing ##1 !flushing)
        else $error("branch did not cost exactly one flush cycle");
    a_fetch_load: assert property (@(posedge clk) disable iff (rst)
        (!branch) |=> (cur.ir == $past(prog_data)))
        else $error("fetched word not latched for execution");
    a_zero_flag: assert property (@(posedge clk) disable iff (rst)
        (executing && upd_z && !is_bit && !is_goto && !is_call && !is_ret)
        |=> (status_value[`ST_ZERO] == ($past(alu_res) == 8'h00)))
        else $error("zero flag wrong");
    a_sub_borrow: assert property (@(posedge clk) disable iff (rst)
        (executing && op == mcu_core_pkg::ALU_SUB && upd_c)
        |=> (status_value[`ST_CARRY] == ($past(alu_a) >= $past(alu_b))))
        else $error("carry not inverted borrow");
    a_add_carry: assert property (@(posedge clk) disable iff (rst)
        (executing && op == mcu_core_pkg::ALU_ADD && upd_c)
        |=> (status_value[`ST_CARRY] == ({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)} > 9'h0ff)))
        else $error("carry out of bit 7 wrong");
    a_nibble_add: assert property (@(posedge clk) disable iff (rst)
        (executing && op == mcu_core_pkg::ALU_ADD && upd_dc)
        |=> (status_value[`ST_NIBBLE]
            == ({1'b0, $past(alu_a[3:0])} + {1'b0, $past(alu_b[3:0])} > 5'h0f)))
        else $error("nibble carry wrong");
    a_w_literal: assert property (@(posedge clk) disable iff (rst)
        (executing && cur.ir[11:8] == `OP_MOVLW) |=> (w_value == $past(cur.ir[7:0])))
        else $error("literal not loaded into working register");
    a_no_flush_wr: assert property (@(posedge clk) disable iff (rst)
        flushing |-> !data_we)
        else $error("data write during flush cycle");

    // reset, discarded slots and jump target
    a_reset_state: assert property (@(posedge clk)
        rst |=> (prog_addr == `PC_RESET && flushing && w_value == `W_RESET
            && status_value == `STATUS_RESET))
        else $error("state after reset wrong");
    a_flush_hold: assert property (@(posedge clk) disable iff (rst)
        flushing |=> (w_value == $past(w_value) && status_value == $past(status_value)))
        else $error("discarded slot changed w or status");
    a_flush_step: assert property (@(posedge clk) disable iff (rst)
        flushing |=> (prog_addr == $past(prog_addr) + 10'h001))
        else $error("fetch stalled in discarded slot");
    a_goto_target: assert property (@(posedge clk) disable iff (rst)
        (executing && is_goto) |=> (prog_addr == {1'b0, $past(cur.ir[8:0])}))
        else $error("jump target wrong");

    // data port and mapped registers
    a_data_refused: assert property (@(posedge clk) disable iff (rst)
        data_we |-> (data_addr != `ADDR_INDF && data_addr != `ADDR_PCL
            && data_addr != `ADDR_STATUS && data_addr != `ADDR_FSR))
        else $error("mapped address strobed on data port");
    a_file_write: assert property (@(posedge clk) disable iff (rst)
        (executing && wr_en && to_file && eff_addr > `ADDR_FSR)
        |-> (data_we && data_wdata == wb_val))
        else $error("file write not strobed");
    a_fsr_write: assert property (@(posedge clk) disable iff (rst)
        (executing && wr_en && to_file && eff_addr == `ADDR_FSR)
        |=> (cur.fsr == $past(wb_val)))
        else $error("pointer register not written");

    // alu results and flags
    a_sub_nibble: assert property (@(posedge clk) disable iff (rst)
        (executing && op == mcu_core_pkg::ALU_SUB && upd_dc)
        |=> (status_value[`ST_NIBBLE] == ($past(alu_a[3:0]) >= $past(alu_b[3:0]))))
        else $error("nibble carry not inverted nibble borrow");
    a_and_result: assert property (@(posedge clk) disable iff (rst)
        (executing && op == mcu_core_pkg::ALU_AND && wr_en && !to_file)
        |=> (w_value == ($past(alu_a) & $past(alu_b))))
        else $error("and result wrong");
    a_rotate_carry: assert property (@(posedge clk) disable iff (rst)
        (executing && op == mcu_core_pkg::ALU_RLF && upd_c)
        |=> (status_value[`ST_CARRY] == $past(alu_a[7])))
        else $error("rotate carry wrong");
    a_flags_kept: assert property (@(posedge clk) disable iff (rst)
        (executing && !upd_z && !upd_c && !upd_dc
            && !(wr_en && to_file && eff_addr == `ADDR_STATUS))
        |=> (status_value == $past(status_value)))
        else $error("status changed without a flag update");
    a_w_writeback: assert property (@(posedge clk) disable iff (rst)
        (executing && !is_ret && wr_en && !to_file)
        |=> (w_value == $past(alu_res)))
        else $error("result not written to w");
endmodule : mcu_core

// ==== test/prog_data_model.sv ====
// program memory and data file model facing the core's two ports
`timescale 1ns/1ns

module prog_data_model (
    input wire logic clk,
    input wire logic [9:0] prog_addr,
    output logic [11:0] prog_data,
    input wire logic [4:0] data_addr,
    output logic [7:0] data_rdata,
    input wire logic [7:0] data_wdata,
    input wire logic data_we
);
    logic [11:0] rom [0:1023];
    logic [7:0] regs [0:31];

    // ==================================================================
    // program port: one whole word answered in the same cycle
    assign prog_data = rom[prog_addr];

    // data read path, independent of the fetch path
    assign data_rdata = regs[data_addr];

    // file byte written on the strobe edge
    always @(posedge clk) begin
        if (data_we) begin
            regs[data_addr] <= data_wdata;
        end
    end
endmodule : prog_data_model

// ==== test/tb_top.sv ====
// self-checking bench for the core datapath against an integer model
`timescale 1ns/1ns

module tb_top;
    logic clk;
    logic rst;
    logic [9:0] prog_addr;
    logic [11:0] prog_data;
    logic [4:0] data_addr;
    logic [7:0] data_rdata;
    logic [7:0] data_wdata;
    logic data_we;
    logic [7:0] w_value;
    logic [7:0] status_value;
    logic flushing;
    int mismatches = 0;
    int checks_done = 0;
    // file add sub and ior xor, literal ior and xor, file inc rol dec com swap ror
    logic [11:0] op_code [14] = '{12'h1c0, 12'h080, 12'h140, 12'h100, 12'h180,
                                  12'hd00, 12'he00, 12'hf00, 12'h280, 12'h340,
                                  12'h0c0, 12'h240, 12'h380, 12'h300};

    // ==================================================================
    // design and partner
    mcu_core u_dut (.clk(clk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
        .data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata),
        .data_we(data_we), .w_value(w_value), .status_value(status_value),
        .flushing(flushing));
    prog_data_model u_mem (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
        .data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata),
        .data_we(data_we));

    // ==================================================================
    // clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ==================================================================
    // compare tasks, one per kind of result
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_addr(input string what, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_addr

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // ==================================================================
    // one program: load operands, pointer, operation, park loop
    task automatic run_case(input int op, input int a, input int b, input bit d, input bit ind);
        int r;
        int c;
        int dc;
        int z;
        int w_exp;
        int f_exp;
        bit lw;
        lw = (op >= 5 && op <= 7);
        for (int i = 0; i < 1024; i++) u_mem.rom[i] = 12'h000;
        u_mem.rom[0] = 12'hc00 | 12'(a);
        u_mem.rom[1] = 12'h030;
        u_mem.rom[2] = 12'hc10;
        u_mem.rom[3] = 12'h024;
        u_mem.rom[4] = 12'hc00 | 12'(lw ? a : b);
        u_mem.rom[5] = lw ? (op_code[op] | 12'(b))
                          : (op_code[op] | {6'h00, d, ind ? 5'h00 : 5'h10});
        u_mem.rom[6] = 12'ha06;
        // integer model of the operation
        c = 0;
        dc = 0;
        case (op)
            0: begin
                r = a + b;
                c = (r > 255);
                dc = ((a & 15) + (b & 15)) > 15;
            end
            1: begin
                r = a - b;
                c = (a >= b);
                dc = ((a & 15) >= (b & 15));
            end
            2, 6: r = a & b;
            3, 5: r = a | b;
            4, 7: r = a ^ b;
            8: r = a + 1;
            9: begin
                r = a << 1;
                c = (a >> 7) & 1;
            end
            10: r = a - 1;
            11: r = ~a;
            12: r = ((a & 15) << 4) | (a >> 4);
            default: begin
                r = a >> 1;
                c = a & 1;
            end
        endcase
        r = r & 255;
        w_exp = (lw || !d) ? r : b;
        f_exp = (!lw && d) ? r : a;
        z = (r == 0 && op != 9 && op < 12);
        // reset, then walk the pipeline
        @(posedge clk);
        #1 rst = 1'b1;
        @(posedge clk);
        #1;
        chk_byte("w_reset", 8'h00, w_value);
        chk_byte("status_reset", 8'h18, status_value);
        chk_bit("flush_reset", 1'b1, flushing);
        chk_addr("pc_reset", 10'h000, prog_addr);
        rst = 1'b0;
        for (int k = 1; k <= 7; k++) begin
            @(posedge clk);
            #1;
            chk_addr("pc_step", 10'(k), prog_addr);
            chk_bit("flush_step", 1'b0, flushing);
        end
        @(posedge clk);
        #1;
        chk_addr("pc_branch", 10'h006, prog_addr);
        chk_bit("flush_branch", 1'b1, flushing);
        chk_byte("w_result", 8'(w_exp), w_value);
        chk_byte("file_result", 8'(f_exp), u_mem.regs[16]);
        chk_byte("status_flags", 8'h18 | 8'(z * 4 + dc * 2 + c),
                 status_value);
        $display("test op=%0d a=%h b=%h d=%0d ind=%0d done", op, a, b, d, ind);
    endtask : run_case

    // ==================================================================
    // main sequence
    initial begin
        int a;
        int b;
        rst = 1'b1;
        for (int i = 0; i < 32; i++) u_mem.regs[i] = 8'h5a;
        void'($urandom(26));
        repeat (5) @(posedge clk);
        for (int op = 0; op < 14; op++) begin
            for (int rep = 0; rep < 4; rep++) begin
                a = $urandom & 255;
                b = (rep == 0) ? a : ($urandom & 255);
                if (rep == 1) begin
                    a = 255;
                    b = 1;
                end
                run_case(op, a, b, rep[0] ^ $urandom_range(0, 1), $urandom_range(0, 1));
            end
        end
        report_and_stop();
    end

    // hang guard, well beyond the expected few hundred cycles
    initial begin
        #40000;
        mismatches++;
        report_and_stop();
    end
endmodule : tb_top
